// ===== verilog/timer_pwm_generator.sv
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "timer_pwm_params.svh"

module timer_pwm_generator
	import timer_pwm_pkg::*;
(
	// Clock and reset
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_NRST,
	// Wishbone slave
	input  wire logic        I_WB_CYC,
	input  wire logic        I_WB_STB,
	input  wire logic        I_WB_WE,
	input  wire logic [7:0]  I_WB_ADR,
	input  wire logic [3:0]  I_WB_SEL,
	input  wire logic [31:0] I_WB_DAT,
	output logic [31:0]      O_WB_DAT,
	output logic             O_WB_ACK,
	// External event pin
	input  wire logic        I_EVENT_PIN,
	// GPIO side of the shared pin
	input  wire logic        I_GPIO_OUT,
	input  wire logic        I_GPIO_OE,
	// Shared pin
	output logic             O_PIN_OUT,
	output logic             O_PIN_OE,
	// Interrupt request
	output logic             O_OVF_IRQ
);

	logic [7:0]  mode_ff;
	logic [7:0]  count_ff;
	logic [7:0]  nxt_count;
	logic [7:0]  reload_buf_ff;
	logic [7:0]  active_ff;
	logic        flag_ff;
	logic        ien_ff;
	logic        pwm_ff;
	logic        buzz_ff;
	logic        pin_ff;
	logic        oe_ff;
	logic        ack_ff;
	logic [31:0] rdat_ff;
	logic        en_d_ff;

	logic        presc_tick;
	logic        event_fall;
	logic        timer_en;
	logic        pwm_mode;
	logic        buzz_mode;
	logic        tick;
	logic        ovf;
	logic [7:0]  cnt_max;
	logic        wb_req;
	logic        wb_wr;
	logic        wr_mode;
	logic        wr_count;
	logic        wr_reload;
	logic        wr_status;
	res_e        res;
	pin_src_e    pin_src;

	// Resolution from the auto-reload and toggle bit pair
	function automatic res_e res_of(input logic [7:0] m);
		res_of = res_e'({m[`TP_BIT_ARELOAD], m[`TP_BIT_TOGGLE]});
	endfunction

	function automatic logic [7:0] max_of(input res_e r);
		case (r)
			RES_256: max_of = `TP_MAX_256;
			RES_64:  max_of = `TP_MAX_64;
			RES_32:  max_of = `TP_MAX_32;
			RES_16:  max_of = `TP_MAX_16;
			default: max_of = `TP_MAX_256;
		endcase
	endfunction

	tpwm_prescaler #(
		.W (8)
	) u_prescaler (
		.i_clk  (I_CORE_CLK),
		.i_nrst (I_NRST),
		.i_sel  (mode_ff[`TP_BIT_PS_HI:`TP_BIT_PS_LO]),
		.o_tick (presc_tick)
	);

	tpwm_event_edge u_event_edge (
		.i_clk  (I_CORE_CLK),
		.i_nrst (I_NRST),
		.i_pin  (I_EVENT_PIN),
		.o_fall (event_fall)
	);

	assign timer_en  = mode_ff[`TP_BIT_ENABLE];
	assign pwm_mode  = mode_ff[`TP_BIT_PWM_OUT];
	assign buzz_mode = mode_ff[`TP_BIT_TOGGLE] & ~pwm_mode;
	assign res       = pwm_mode ? res_of(mode_ff) : RES_256;
	assign cnt_max   = max_of(res);

	// Timer clock: prescaled core clock or external falling edges
	assign tick = timer_en & (mode_ff[`TP_BIT_CLKSRC] ? event_fall
		: presc_tick);
	assign ovf  = tick & (count_ff == cnt_max);

	// Wishbone decode; the write lands on the edge that also sees ack
	assign wb_req    = I_WB_CYC & I_WB_STB;
	assign wb_wr     = wb_req & I_WB_WE & ack_ff & I_WB_SEL[0];
	assign wr_mode   = wb_wr & (I_WB_ADR == `TP_OFS_MODE);
	assign wr_count  = wb_wr & (I_WB_ADR == `TP_OFS_COUNT);
	assign wr_reload = wb_wr & (I_WB_ADR == `TP_OFS_RELOAD);
	assign wr_status = wb_wr & (I_WB_ADR == `TP_OFS_STATUS);

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= wb_req & ~ack_ff;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rdat_ff <= 32'h0000_0000;
		end else if (wb_req & ~ack_ff) begin
			case (I_WB_ADR)
				`TP_OFS_MODE:   rdat_ff <= {24'h000000, mode_ff};
				`TP_OFS_COUNT:  rdat_ff <= {24'h000000, count_ff};
				`TP_OFS_STATUS: rdat_ff <= {30'h0, ien_ff, flag_ff};
				default:        rdat_ff <= 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			mode_ff <= `TP_RST_MODE;
		end else if (wr_mode) begin
			mode_ff <= I_WB_DAT[7:0];
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			en_d_ff <= 1'b0;
		end else begin
			en_d_ff <= timer_en;
		end
	end

	// Count: overflow reloads zero in PWM mode, buffer with auto-reload
	always_comb begin
		nxt_count = count_ff;
		if (timer_en & ~en_d_ff & pwm_mode) begin
			nxt_count = `TP_RST_COUNT;
		end else if (ovf) begin
			if (pwm_mode | ~mode_ff[`TP_BIT_ARELOAD]) begin
				nxt_count = `TP_RST_COUNT;
			end else begin
				nxt_count = reload_buf_ff;
			end
		end else if (tick) begin
			nxt_count = count_ff + 8'h01;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			count_ff <= `TP_RST_COUNT;
		end else if (wr_count) begin
			count_ff <= I_WB_DAT[7:0];
		end else begin
			count_ff <= nxt_count;
		end
	end

	// Double buffer keeps a mid-period duty write from glitching the output
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			reload_buf_ff <= `TP_RST_RELOAD;
		end else if (wr_reload) begin
			reload_buf_ff <= I_WB_DAT[7:0];
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			active_ff <= `TP_RST_RELOAD;
		end else if (ovf) begin
			active_ff <= reload_buf_ff;
		end
	end

	// Set beats a clear in the same cycle
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			flag_ff <= 1'b0;
		end else if (ovf) begin
			flag_ff <= 1'b1;
		end else if (wr_status & I_WB_DAT[`TP_BIT_OVF_FLAG]) begin
			flag_ff <= 1'b0;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			ien_ff <= 1'b0;
		end else if (wr_status) begin
			ien_ff <= I_WB_DAT[`TP_BIT_OVF_IEN];
		end
	end

	// High while count is below the duty; one cycle behind the count
	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pwm_ff <= 1'b0;
		end else begin
			pwm_ff <= timer_en & (count_ff < active_ff);
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			buzz_ff <= 1'b0;
		end else if (ovf & buzz_mode) begin
			buzz_ff <= ~buzz_ff;
		end
	end

	// Pin ownership; GPIO settings are never overwritten, only bypassed
	always_comb begin
		if (pwm_mode & timer_en) begin
			pin_src = PIN_PWM;
		end else if (buzz_mode) begin
			pin_src = PIN_BUZZ;
		end else begin
			pin_src = PIN_GPIO;
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			pin_ff <= 1'b0;
			oe_ff  <= 1'b0;
		end else begin
			case (pin_src)
				PIN_PWM: begin
					pin_ff <= pwm_ff;
					oe_ff  <= 1'b1;
				end
				PIN_BUZZ: begin
					pin_ff <= buzz_ff;
					oe_ff  <= 1'b1;
				end
				default: begin
					pin_ff <= I_GPIO_OUT;
					oe_ff  <= I_GPIO_OE;
				end
			endcase
		end
	end

	assign O_PIN_OUT = pin_ff;
	assign O_PIN_OE  = oe_ff;
	assign O_OVF_IRQ = flag_ff & ien_ff;
	assign O_WB_ACK  = ack_ff;
	assign O_WB_DAT  = rdat_ff;

	property p_pin_owner;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		(pwm_mode & timer_en) |=> (O_PIN_OE && O_PIN_OUT == $past(pwm_ff));
	endproperty
	a_pin_owner: assert property (p_pin_owner)
		else $error("pin not driven by PWM while PWM enabled");

	property p_restart_zero;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		(ovf & pwm_mode & ~wr_count) |=> (count_ff == 8'h00);
	endproperty
	a_restart_zero: assert property (p_restart_zero)
		else $error("PWM count did not restart at zero");

	property p_low_at_match;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		(timer_en & (count_ff == active_ff)) |=> !pwm_ff;
	endproperty
	a_low_at_match: assert property (p_low_at_match)
		else $error("PWM stayed high at duty match");

	property p_high_after_ovf;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		(ovf & pwm_mode & (reload_buf_ff != 8'h00) & ~wr_count)
			##1 timer_en |=> pwm_ff;
	endproperty
	a_high_after_ovf: assert property (p_high_after_ovf)
		else $error("PWM did not go high at period start");

	property p_duty_load;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		ovf |=> (active_ff == $past(reload_buf_ff));
	endproperty
	a_duty_load: assert property (p_duty_load)
		else $error("active duty not loaded at overflow");

	property p_buffer_only;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		!ovf |=> $stable(active_ff);
	endproperty
	a_buffer_only: assert property (p_buffer_only)
		else $error("active duty changed without overflow");

	property p_flag_sticky;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		ovf |=> flag_ff ##1 (flag_ff || $past(wr_status));
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("overflow flag not set or lost");

	property p_irq;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		(ovf & ien_ff & ~wr_status) |=> O_OVF_IRQ;
	endproperty
	a_irq: assert property (p_irq)
		else $error("no interrupt after enabled overflow");

	property p_res_bound;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		(pwm_mode & mode_ff[`TP_BIT_ARELOAD] & mode_ff[`TP_BIT_TOGGLE]
			& (count_ff == 8'h0F) & tick & ~wr_count) |=> (count_ff == 8'h00);
	endproperty
	a_res_bound: assert property (p_res_bound)
		else $error("16 step resolution did not wrap");

	property p_buzz_toggle;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		(ovf & buzz_mode) |=> (buzz_ff != $past(buzz_ff));
	endproperty
	a_buzz_toggle: assert property (p_buzz_toggle)
		else $error("buzzer did not toggle at overflow");

	property p_hold_disabled;
		@(posedge I_CORE_CLK) disable iff (!I_NRST)
		(!timer_en & ~wr_count) |=> ($stable(count_ff) && !$rose(flag_ff));
	endproperty
	a_hold_disabled: assert property (p_hold_disabled)
		else $error("disabled timer changed count or flag");

endmodule // timer_pwm_generator

`default_nettype wire

// ===== verilog/timer_pwm_params.svh
`ifndef TIMER_PWM_PARAMS_SVH
`define TIMER_PWM_PARAMS_SVH

// Register byte offsets on the Wishbone slave
`define TP_OFS_MODE      8'h00
`define TP_OFS_COUNT     8'h04
`define TP_OFS_RELOAD    8'h08
`define TP_OFS_STATUS    8'h0C

// Mode register field positions
`define TP_BIT_PWM_OUT   0
`define TP_BIT_TOGGLE    1
`define TP_BIT_ARELOAD   2
`define TP_BIT_CLKSRC    3
`define TP_BIT_PS_LO     4
`define TP_BIT_PS_HI     6
`define TP_BIT_ENABLE    7

// Status register field positions
`define TP_BIT_OVF_FLAG  0
`define TP_BIT_OVF_IEN   1

// Reset values
`define TP_RST_MODE      8'h00
`define TP_RST_COUNT     8'h00
`define TP_RST_RELOAD    8'h00

// Count limits per resolution
`define TP_MAX_256       8'hFF
`define TP_MAX_64        8'h3F
`define TP_MAX_32        8'h1F
`define TP_MAX_16        8'h0F

`endif

// ===== verilog/timer_pwm_pkg.sv
package timer_pwm_pkg;

	typedef enum logic [1:0] {
		RES_256,
		RES_64,
		RES_32,
		RES_16
	} res_e;

	typedef enum logic [1:0] {
		PIN_GPIO,
		PIN_PWM,
		PIN_BUZZ
	} pin_src_e;

endpackage

// ===== verilog/tpwm_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_pwm_params.svh"

module tpwm_prescaler #(
	parameter int W = 8
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_nrst,
	// Control
	input  wire logic [2:0]   i_sel,
	// Output
	output logic              o_tick
);

	logic [W-1:0] div_ff;
	logic         tick_ff;

	// Select 000 divides by 256, each step halves the divisor
	function automatic logic [W-1:0] div_mask(input logic [2:0] sel);
		div_mask = {W{1'b1}} >> sel;
	endfunction

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			div_ff <= '0;
		end else begin
			div_ff <= div_ff + 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= ((div_ff & div_mask(i_sel)) == div_mask(i_sel));
		end
	end

	assign o_tick = tick_ff;

endmodule // tpwm_prescaler

`default_nettype wire

// ===== verilog/tpwm_event_edge.sv
`timescale 1ns/10ps
`default_nettype none

module tpwm_event_edge (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_nrst,
	// Event pin
	input  wire logic i_pin,
	// Output
	output logic      o_fall
);

	logic pin_ff;
	logic fall_ff;

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			pin_ff <= 1'b1;
		end else begin
			pin_ff <= i_pin;
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			fall_ff <= 1'b0;
		end else begin
			fall_ff <= pin_ff & ~i_pin;
		end
	end

	assign o_fall = fall_ff;

	property p_fall_one_shot;
		@(posedge i_clk) disable iff (!i_nrst)
		o_fall |=> !o_fall;
	endproperty
	a_fall_one_shot: assert property (p_fall_one_shot)
		else $error("event fall pulse lasted two cycles");

endmodule // tpwm_event_edge

`default_nettype wire

// ===== dv/timer_pwm_generator_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer_pwm_params.svh"

module timer_pwm_generator_tb
	import timer_pwm_pkg::*;
;
	typedef struct {
		logic [31:0] exp;
		int          tol;
	} note_s;

	logic        clk;
	logic        nrst;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] wdat;
	logic        evt;
	logic        gpio_out;
	logic        gpio_oe;
	wire logic [31:0] rdat;
	wire logic        ack;
	wire logic        pin_out;
	wire logic        pin_oe;
	wire logic        irq;
	note_s       exp_q[$];
	note_s       nt;
	int          num_errors;
	int          total_checks;
	int          cycles;
	int          r;
	int          mx;
	int          per;
	int          duty;
	int          hi;
	int          rises;
	logic [31:0] rng;
	logic [31:0] rv;

	timer_pwm_generator dut_u (
		.I_CORE_CLK  (clk),
		.I_NRST      (nrst),
		.I_WB_CYC    (cyc),
		.I_WB_STB    (stb),
		.I_WB_WE     (we),
		.I_WB_ADR    (adr),
		.I_WB_SEL    (sel),
		.I_WB_DAT    (wdat),
		.O_WB_DAT    (rdat),
		.O_WB_ACK    (ack),
		.I_EVENT_PIN (evt),
		.I_GPIO_OUT  (gpio_out),
		.I_GPIO_OE   (gpio_oe),
		.O_PIN_OUT   (pin_out),
		.O_PIN_OE    (pin_oe),
		.O_OVF_IRQ   (irq)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	function automatic logic [31:0] next_rand();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Holds the request until ack is seen at an edge, then releases
	task automatic wb(input logic w, input logic [7:0] a, input int d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d[7:0]};
		@(posedge clk);
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input int e, input int tol);
		exp_q.push_back('{exp: e, tol: tol});
		wb(1'b0, a, 0);
	endtask

	task automatic measure(input int n);
		logic prev;
		prev = pin_out;
		hi = 0;
		rises = 0;
		repeat (n) begin
			@(posedge clk);
			if (pin_out === 1'b1 && prev === 1'b0)
				rises++;
			if (pin_out === 1'b1)
				hi++;
			prev = pin_out;
		end
	endtask

	// Read results are judged where the ack shows up, oldest note first
	always @(posedge clk) begin
		if (ack === 1'b1 && we === 1'b0) begin
			if (exp_q.size() == 0) begin
				check("unexpected read", rdat, 32'hFFFF_FFFF);
			end else begin
				nt = exp_q.pop_front();
				if (nt.tol != 0 && ^rdat !== 1'bx &&
					int'(rdat) - int'(nt.exp) <= nt.tol &&
					int'(nt.exp) - int'(rdat) <= nt.tol)
					check("read data", nt.exp, nt.exp);
				else
					check("read data", rdat, nt.exp);
			end
		end
	end

	task wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		cycles = 0;
		while (cycles < 20000) begin
			@(posedge clk);
			cycles++;
		end
		num_errors++;
		$display("timeout after %0d cycles", cycles);
		wrap_up();
	end

	initial begin
		nrst = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hF;
		wdat = 32'h0;
		evt = 1'b1;
		gpio_out = 1'b0;
		gpio_oe = 1'b0;
		rng = 32'h10;
		num_errors = 0;
		total_checks = 0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(`TP_OFS_MODE, 0, 0);
		rd(`TP_OFS_COUNT, 0, 0);
		rd(`TP_OFS_RELOAD, 0, 0);
		rd(`TP_OFS_STATUS, 0, 0);
		wb(1'b1, 8'h10, 8'hFF);
		rd(8'h10, 0, 0);
		for (r = 0; r < 4; r++) begin
			rv = next_rand();
			gpio_out <= r[0] ^ rv[0];
			gpio_oe <= rv[1];
			repeat (3) @(posedge clk);
			check("gpio level", pin_out, gpio_out);
			check("gpio enable", pin_oe, gpio_oe);
		end
		// Every resolution, random duty kept inside its range
		for (r = 0; r < 4; r++) begin
			mx = (r == 0) ? 255 : (r == 1) ? 63 : (r == 2) ? 31 : 15;
			per = (mx + 1) * 2;
			duty = next_rand() % mx + 1;
			wb(1'b1, `TP_OFS_MODE, 8'h00);
			wb(1'b1, `TP_OFS_MODE, 8'h70);
			wb(1'b1, `TP_OFS_MODE, 8'h70 | (r << 1));
			wb(1'b1, `TP_OFS_RELOAD, duty);
			wb(1'b1, `TP_OFS_COUNT, 0);
			wb(1'b1, `TP_OFS_STATUS, 8'h03);
			wb(1'b1, `TP_OFS_MODE, 8'hF0 | (r << 1));
			wb(1'b1, `TP_OFS_MODE, 8'hF1 | (r << 1));
			repeat (2 * per) @(posedge clk);
			measure(2 * per);
			check("high cycles", hi, 4 * duty);
			check("period starts", rises, 2);
			check("pwm enable", pin_oe, 1'b1);
			check("irq", irq, 1'b1);
			rd(`TP_OFS_STATUS, 3, 0);
			duty = next_rand() % mx + 1;
			wb(1'b1, `TP_OFS_RELOAD, duty);
			repeat (2 * per) @(posedge clk);
			measure(2 * per);
			check("new duty", hi, 4 * duty);
		end
		// Gate the carrier off with the timer still running
		// Toggle bit would become buzzer enable, so gate from 32 steps
		gpio_out <= 1'b1;
		gpio_oe <= 1'b1;
		wb(1'b1, `TP_OFS_MODE, 8'hF5);
		wb(1'b1, `TP_OFS_MODE, 8'hF4);
		wb(1'b1, `TP_OFS_STATUS, 8'h03);
		repeat (3) @(posedge clk);
		check("gated level", pin_out, 1'b1);
		check("gated enable", pin_oe, 1'b1);
		// Gated timer counts up to the 256 step limit, then reloads the buffer
		repeat (600) @(posedge clk);
		rd(`TP_OFS_STATUS, 3, 0);
		wb(1'b1, `TP_OFS_MODE, 8'h77);
		wb(1'b1, `TP_OFS_STATUS, 8'h03);
		repeat (2 * per) @(posedge clk);
		rd(`TP_OFS_STATUS, 2, 0);
		check("disabled pin", pin_out, gpio_out);
		check("disabled enable", pin_oe, gpio_oe);
		for (r = 4; r < 8; r++) begin
			wb(1'b1, `TP_OFS_MODE, 8'h00);
			wb(1'b1, `TP_OFS_COUNT, 0);
			wb(1'b1, `TP_OFS_MODE, 8'h80 | (r << 4));
			repeat (253) @(posedge clk);
			wb(1'b1, `TP_OFS_MODE, r << 4);
			rd(`TP_OFS_COUNT, 1 << r, 1);
		end
		wb(1'b1, `TP_OFS_MODE, 8'h00);
		wb(1'b1, `TP_OFS_COUNT, 0);
		wb(1'b1, `TP_OFS_MODE, 8'h08);
		wb(1'b1, `TP_OFS_MODE, 8'h88);
		repeat (10) begin
			evt <= 1'b0;
			repeat (3) @(posedge clk);
			evt <= 1'b1;
			repeat (3) @(posedge clk);
		end
		repeat (4) @(posedge clk);
		wb(1'b1, `TP_OFS_MODE, 8'h08);
		rd(`TP_OFS_COUNT, 10, 0);
		// Buzzer: 16 ticks of two cycles between overflows
		wb(1'b1, `TP_OFS_MODE, 8'h00);
		wb(1'b1, `TP_OFS_MODE, 8'h74);
		wb(1'b1, `TP_OFS_COUNT, 8'hF0);
		wb(1'b1, `TP_OFS_RELOAD, 8'hF0);
		wb(1'b1, `TP_OFS_MODE, 8'hF4);
		wb(1'b1, `TP_OFS_MODE, 8'hF6);
		repeat (70) @(posedge clk);
		measure(320);
		check("buzzer rises", rises, 5);
		check("buzzer high", hi, 160);
		check("buzzer enable", pin_oe, 1'b1);
		repeat (3) @(posedge clk);
		if (exp_q.size() != 0)
			num_errors++;
		wrap_up();
	end
endmodule // timer_pwm_generator_tb
`default_nettype wire
